// ---- cexu_core_model.sv ----
// core-side model: program counter, status and r15 that feed the entry unit
`timescale 1ns/1ps
module cexu_core_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic fd_set,
  input wire logic sr_load,
  input wire logic [31:0] sr_value,
  input wire logic pc_load,
  input wire logic [31:0] pc_value,
  output logic [31:0] cur_pc,
  output logic [31:0] cur_sr,
  output logic [31:0] cur_r15,
  output logic [31:0] vector_base
);
  // base kept in an untranslated region so a handler fetch cannot fault again
  assign vector_base = 32'h8C080000;
  // r15 is owned by the core; a return must leave it alone
  assign cur_r15 = 32'h0C00FFF0;
  // pc and status follow the load pulses; fd_set mimics handler code setting fp disable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur_pc <= 32'h0C001000;
      cur_sr <= 32'h00008000;
    end else begin
      if (pc_load) cur_pc <= pc_value;
      if (sr_load) cur_sr <= sr_value;
      if (fd_set) cur_sr[15] <= 1'b1;
    end
  end
endmodule

// ---- cexu_entry_unit.sv ----
// exception entry unit: event code and mask registers, slot checks, entry sequencer and return
`timescale 1ns/1ps
`include "cexu_regs.svh"
module cexu_entry_unit import cexu_pkg::*; #(
  parameter int N = 8,
  parameter int IW = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  input wire logic [N-1:0] req_pend,
  input wire logic [N*3-1:0] req_level,
  input wire logic [N*4-1:0] req_order,
  input wire logic [N*12-1:0] req_code,
  input wire logic [N*12-1:0] req_offset,
  input wire logic [N*2-1:0] req_kind,
  input wire logic [3:0] irq_accept_level,
  input wire logic irq_level_update_switch,
  input wire logic [31:0] vector_base,
  input wire logic [31:0] cur_pc,
  input wire logic [31:0] cur_sr,
  input wire logic [31:0] cur_r15,
  input wire logic return_from_exception_instr,
  input wire logic icache_invalidate_instr,
  input wire logic dec_valid,
  input wire logic dec_in_return_slot,
  input wire logic dec_is_nop,
  input wire logic dec_in_branch_slot,
  input wire logic dec_is_sleep,
  input wire logic cache_assoc_req,
  output logic slot_illegal_raise,
  output logic addr_error_raise,
  output logic cache_assoc_grant,
  output logic entry_busy,
  output logic entry_ack,
  output logic [IW-1:0] entry_idx,
  output logic [31:0] saved_program_counter,
  output logic [31:0] saved_status,
  output logic [31:0] saved_general_reg,
  output logic sr_load,
  output logic [31:0] sr_value,
  output logic pc_load,
  output logic [31:0] pc_value
);

  // address match against the control area and its physical alias
  function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] base);
    logic area_ok;
    area_ok = (addr[31:29] == `CEXU_AREA_CTRL) || (addr[31:29] == `CEXU_AREA_PHYS);
    return area_ok && (addr[28:0] == base[28:0]);
  endfunction

  cexu_state_e state;
  logic [`CEXU_EXC_CODE_W-1:0] exception_event_code;
  logic [`CEXU_INT_CODE_W-1:0] interrupt_event_code;
  logic [4:0] legacy_feature_mask;
  logic [4:0] active_mask;
  logic mask_pending;
  logic mask_read_back;
  logic por_pending;
  logic [IW-1:0] lat_idx;
  cexu_kind_e lat_kind;
  logic [11:0] lat_code;
  logic [11:0] lat_offset;
  logic [3:0] lat_level;

  // register decode
  logic hit_exc;
  logic hit_int;
  logic hit_mask;
  logic wr_exc;
  logic wr_int;
  logic wr_mask;
  logic rd_mask;
  logic [31:0] rd_word;
  assign hit_exc = reg_hit(reg_addr, `CEXU_EXC_EVENT_ADDR);
  assign hit_int = reg_hit(reg_addr, `CEXU_INT_EVENT_ADDR);
  assign hit_mask = reg_hit(reg_addr, `CEXU_MASK_ADDR);
  assign wr_exc = reg_wr && hit_exc;
  assign wr_int = reg_wr && hit_int;
  assign wr_mask = reg_wr && hit_mask;
  assign rd_mask = reg_rd && hit_mask;

  // read mux; unmapped addresses read zero, reserved high bits read zero
  assign rd_word = hit_exc ? {20'h00000, exception_event_code} :
                   hit_int ? {18'h00000, interrupt_event_code} :
                   hit_mask ? {27'h0000000, legacy_feature_mask} :
                   32'h00000000;

  // priority keys: level above order so level decides first
  logic [N*7-1:0] req_key;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_key
      assign req_key[g*7 +: 7] = {req_level[g*3 +: 3], req_order[g*4 +: 4]};
    end
  endgenerate

  logic pick_any;
  logic [IW-1:0] pick_idx;
  cexu_prio_pick #(
    .N(N),
    .IW(IW)
  ) u_pick (
    .req(req_pend),
    .key(req_key),
    .any(pick_any),
    .win(pick_idx)
  );

  // fields of the winning request
  logic [11:0] pick_code;
  logic [11:0] pick_offset;
  logic [1:0] pick_kind;
  assign pick_code = req_code[pick_idx*12 +: 12];
  assign pick_offset = req_offset[pick_idx*12 +: 12];
  assign pick_kind = req_kind[pick_idx*2 +: 2];

  // entry start: power-on reset is served first, then the arbitrated request
  logic start_entry;
  logic start_return;
  assign start_entry = (state == CEXU_IDLE) && (por_pending || pick_any);
  assign start_return = (state == CEXU_IDLE) && !start_entry && return_from_exception_instr;

  // status image built from the saved status
  logic [31:0] sr_entry;
  logic [31:0] sr_block_set;
  logic [31:0] sr_fp_fixed;
  logic irq_mask_update;
  assign sr_block_set = saved_status | (32'h00000001 << `CEXU_SR_BLOCK)
                      | (32'h00000001 << `CEXU_SR_MODE)
                      | (32'h00000001 << `CEXU_SR_BANK);
  assign sr_fp_fixed = (lat_kind == CEXU_KIND_RESET) ?
                       (sr_block_set & ~(32'h00000001 << `CEXU_SR_FP_DISABLE)) : sr_block_set;
  assign irq_mask_update = (lat_kind == CEXU_KIND_INTERRUPT) && irq_level_update_switch;
  always_comb begin
    sr_entry = sr_fp_fixed;
    if (irq_mask_update) begin
      sr_entry[`CEXU_SR_INTERRUPT_MASK_LEVEL_HI:`CEXU_SR_INTERRUPT_MASK_LEVEL_LO] = lat_level;
    end
  end

  // handler address; the vector base is not consulted for resets
  logic [31:0] vector_addr;
  assign vector_addr = (lat_kind == CEXU_KIND_RESET) ? `CEXU_RESET_VECTOR :
                       (vector_base + {20'h00000, lat_offset});

  // slot and cache checks against the mask that is in force
  logic next_slot_illegal;
  logic next_addr_error;
  logic next_assoc_grant;
  assign next_slot_illegal = dec_valid && (
    (dec_in_return_slot && !dec_is_nop && !active_mask[`CEXU_MASK_RETURN_SLOT]) ||
    (dec_in_branch_slot && dec_is_sleep && !active_mask[`CEXU_MASK_BRANCH_SLEEP]));
  assign next_addr_error = cache_assoc_req && !active_mask[`CEXU_MASK_ASSOC_WRITE];
  assign next_assoc_grant = cache_assoc_req && active_mask[`CEXU_MASK_ASSOC_WRITE];

  // mask becomes active only after store, read back and a synchronising instruction
  logic mask_commit;
  assign mask_commit = mask_pending && mask_read_back && !wr_mask &&
                       (return_from_exception_instr || icache_invalidate_instr);

  // register bus answer one cycle after the access
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h00000000;
      reg_ack <= 1'b0;
    end else begin
      reg_ack <= reg_wr | reg_rd;
      reg_rdata <= reg_rd ? rd_word : 32'h00000000;
    end
  end

  // software view of the mask; reserved bits 3 and 2 are pinned high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      legacy_feature_mask <= `CEXU_MASK_RESET;
    end else if (wr_mask) begin
      legacy_feature_mask <= (reg_wdata[4:0] & `CEXU_MASK_WRITABLE) | `CEXU_MASK_FIXED_ONES;
    end
  end

  // handshake tracking for the mask update; a new store restarts it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mask_pending <= 1'b0;
      mask_read_back <= 1'b0;
      active_mask <= `CEXU_MASK_RESET;
    end else if (wr_mask) begin
      mask_pending <= 1'b1;
      mask_read_back <= 1'b0;
    end else if (mask_commit) begin
      active_mask <= legacy_feature_mask;
      mask_pending <= 1'b0;
      mask_read_back <= 1'b0;
    end else if (rd_mask && mask_pending) begin
      mask_read_back <= 1'b1;
    end
  end

  // check results go out registered, one cycle after the decoder offers them
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slot_illegal_raise <= 1'b0;
      addr_error_raise <= 1'b0;
      cache_assoc_grant <= 1'b0;
    end else begin
      slot_illegal_raise <= next_slot_illegal;
      addr_error_raise <= next_addr_error;
      cache_assoc_grant <= next_assoc_grant;
    end
  end

  // entry sequencer; requests are ignored until the branch step ends
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= CEXU_IDLE;
    end else begin
      unique case (state)
        CEXU_IDLE: begin
          if (start_entry) begin
            state <= CEXU_SAVE;
          end
        end
        CEXU_SAVE: state <= CEXU_STATUS;
        CEXU_STATUS: state <= CEXU_CODE;
        CEXU_CODE: state <= CEXU_BRANCH;
        CEXU_BRANCH: state <= CEXU_IDLE;
      endcase
    end
  end

  // power-on reset entry is owed once after each release of resetn
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      por_pending <= 1'b1;
    end else if (start_entry) begin
      por_pending <= 1'b0;
    end
  end

  // winner is latched at start so later request changes cannot disturb the sequence
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lat_idx <= '0;
      lat_kind <= CEXU_KIND_RESET;
      lat_code <= `CEXU_POWER_ON_CODE;
      lat_offset <= 12'h000;
      lat_level <= 4'h0;
    end else if (start_entry) begin
      lat_idx <= pick_idx;
      lat_kind <= por_pending ? CEXU_KIND_RESET : cexu_kind_e'(pick_kind);
      lat_code <= por_pending ? `CEXU_POWER_ON_CODE : pick_code;
      lat_offset <= pick_offset;
      lat_level <= irq_accept_level;
    end
  end

  // context save at the first step of entry
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      saved_program_counter <= 32'h00000000;
      saved_status <= 32'h00000000;
      saved_general_reg <= 32'h00000000;
    end else if (state == CEXU_SAVE) begin
      saved_program_counter <= cur_pc;
      saved_status <= cur_sr;
      saved_general_reg <= cur_r15;
    end
  end

  // exception event register: hardware load beats a software write in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      exception_event_code <= `CEXU_EXC_EVENT_RESET;
    end else if ((state == CEXU_CODE) && (lat_kind != CEXU_KIND_INTERRUPT)) begin
      exception_event_code <= lat_code;
    end else if (wr_exc) begin
      exception_event_code <= reg_wdata[`CEXU_EXC_CODE_W-1:0];
    end
  end

  // interrupt event register: code lands in bits 11 to 0, upper code bits cleared
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      interrupt_event_code <= `CEXU_INT_EVENT_RESET;
    end else if ((state == CEXU_CODE) && (lat_kind == CEXU_KIND_INTERRUPT)) begin
      interrupt_event_code <= {2'b00, lat_code};
    end else if (wr_int) begin
      interrupt_event_code <= reg_wdata[`CEXU_INT_CODE_W-1:0];
    end
  end

  // status load during entry, or restore on return; register 15 has no restore path
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sr_load <= 1'b0;
      sr_value <= 32'h00000000;
    end else begin
      sr_load <= (state == CEXU_STATUS) || start_return;
      if (state == CEXU_STATUS) begin
        sr_value <= sr_entry;
      end else if (start_return) begin
        sr_value <= saved_status;
      end
    end
  end

  // fetch redirect: handler vector at the end of entry, saved counter on return
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc_load <= 1'b0;
      pc_value <= 32'h00000000;
    end else begin
      pc_load <= (state == CEXU_BRANCH) || start_return;
      if (state == CEXU_BRANCH) begin
        pc_value <= vector_addr;
      end else if (start_return) begin
        pc_value <= saved_program_counter;
      end
    end
  end

  // busy holds the pipeline off from the start of entry until the redirect is out
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      entry_busy <= 1'b1;
      entry_ack <= 1'b0;
      entry_idx <= '0;
    end else begin
      entry_busy <= start_entry || ((state != CEXU_IDLE) && (state != CEXU_BRANCH));
      entry_ack <= (state == CEXU_BRANCH);
      entry_idx <= lat_idx;
    end
  end

endmodule

// ---- cexu_entry_unit_chk.sv ----
// assertion checker for the exception entry unit ports
`timescale 1ns/1ps
`include "cexu_regs.svh"
module cexu_entry_unit_chk import cexu_pkg::*; #(
  parameter int N = 8,
  parameter int IW = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic [N-1:0] req_pend,
  input wire logic [N*12-1:0] req_offset,
  input wire logic [N*2-1:0] req_kind,
  input wire logic [31:0] vector_base,
  input wire logic dec_valid,
  input wire logic dec_in_return_slot,
  input wire logic dec_is_nop,
  input wire logic dec_is_sleep,
  input wire logic cache_assoc_req,
  input wire logic slot_illegal_raise,
  input wire logic addr_error_raise,
  input wire logic cache_assoc_grant,
  input wire logic entry_busy,
  input wire logic entry_ack,
  input wire logic [IW-1:0] entry_idx,
  input wire logic [31:0] saved_program_counter,
  input wire logic [31:0] saved_status,
  input wire logic sr_load,
  input wire logic [31:0] sr_value,
  input wire logic pc_load,
  input wire logic [31:0] pc_value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // requests may drop as soon as the ack shows, so the served source is looked up in last cycle's copy
  logic [N-1:0] pend_q;
  logic [N*12-1:0] off_q;
  logic [N*2-1:0] kind_q;
  always_ff @(posedge clk) begin
    pend_q <= req_pend;
    off_q <= req_offset;
    kind_q <= req_kind;
  end
  wire [1:0] kind_s = kind_q[entry_idx*2 +: 2];
  wire [31:0] off_s = {20'h0, off_q[entry_idx*12 +: 12]};
  wire live_s = pend_q[entry_idx];

  a_ack_next_cycle: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("register access not acknowledged");
  a_int_upper_zero: assert property (reg_rd && reg_addr == `CEXU_INT_EVENT_ADDR |=> reg_rdata[31:14] == 18'h0)
    else $error("interrupt code upper bits not zero");
  a_mask_read_fixed: assert property (reg_rd && reg_addr == `CEXU_MASK_ADDR |=> reg_rdata[31:5] == 27'h0
    && reg_rdata[3:2] == 2'h3)
    else $error("mask fixed bits wrong");
  a_nop_slot_legal: assert property (dec_valid && dec_in_return_slot && dec_is_nop && !dec_is_sleep
    |=> !slot_illegal_raise)
    else $error("no-op in return slot flagged");
  a_idle_no_slot: assert property (!dec_valid |=> !slot_illegal_raise)
    else $error("slot illegal without a decode");
  a_assoc_one_answer: assert property (cache_assoc_req |=> addr_error_raise != cache_assoc_grant)
    else $error("associative write answer wrong");
  a_status_bits_set: assert property (sr_load && entry_busy |-> sr_value[30:28] == 3'h7)
    else $error("entry status bits not set");
  a_reset_vector: assert property (entry_ack && live_s && kind_s == 2'h0 |-> pc_value == `CEXU_RESET_VECTOR)
    else $error("reset entry vector wrong");
  a_base_offset: assert property (entry_ack && live_s && kind_s != 2'h0 |-> pc_value == vector_base + off_s)
    else $error("entry vector not base plus offset");
  a_entry_unbroken: assert property (entry_ack |-> !entry_busy && $past(entry_busy) && $past(entry_busy, 3))
    else $error("entry sequence length wrong");
  a_return_restore: assert property (pc_load && !entry_ack |-> sr_load && pc_value == saved_program_counter
    && sr_value == saved_status)
    else $error("return did not restore saved copies");

  c_interrupt_entry: cover property (entry_ack && live_s && kind_s == 2'h2);
  c_return: cover property (pc_load && !entry_ack);
  c_addr_error: cover property (addr_error_raise);
endmodule

bind cexu_entry_unit cexu_entry_unit_chk #(.N(N), .IW(IW)) u_chk (.clk, .resetn, .reg_wr, .reg_rd, .reg_addr,
  .reg_rdata, .reg_ack, .req_pend, .req_offset, .req_kind, .vector_base, .dec_valid, .dec_in_return_slot,
  .dec_is_nop, .dec_is_sleep, .cache_assoc_req, .slot_illegal_raise, .addr_error_raise, .cache_assoc_grant,
  .entry_busy, .entry_ack, .entry_idx, .saved_program_counter, .saved_status, .sr_load, .sr_value, .pc_load,
  .pc_value);

// ---- cexu_pkg.sv ----
// types shared by the exception entry unit files
package cexu_pkg;

  // class of a pending event
  typedef enum logic [1:0] {
    CEXU_KIND_RESET,
    CEXU_KIND_GENERAL,
    CEXU_KIND_INTERRUPT,
    CEXU_KIND_SPARE
  } cexu_kind_e;

  // entry sequencer states
  typedef enum logic [2:0] {
    CEXU_IDLE,
    CEXU_SAVE,
    CEXU_STATUS,
    CEXU_CODE,
    CEXU_BRANCH
  } cexu_state_e;

  // priority key: level in the upper bits, order in the lower bits
  typedef logic [6:0] cexu_key_t;

endpackage

// ---- cexu_prio_pick.sv ----
// picks the pending event with the lowest priority key
`timescale 1ns/1ps
module cexu_prio_pick import cexu_pkg::*; #(
  parameter int N = 8,
  parameter int IW = 3
) (
  input wire logic [N-1:0] req,
  input wire logic [N*7-1:0] key,
  output logic any,
  output logic [IW-1:0] win
);

  logic [N:0] have;
  cexu_key_t best_key [N+1];
  logic [IW-1:0] best_idx [N+1];

  assign have[0] = 1'b0;
  assign best_key[0] = 7'h7F;
  assign best_idx[0] = '0;

  // linear scan; strict less-than keeps the lower index on a tie
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_scan
      logic take;
      assign take = req[i] && (!have[i] || (key[i*7 +: 7] < best_key[i]));
      assign have[i+1] = have[i] | req[i];
      assign best_key[i+1] = take ? key[i*7 +: 7] : best_key[i];
      assign best_idx[i+1] = take ? IW'(i) : best_idx[i];
    end
  endgenerate

  assign any = have[N];
  assign win = best_idx[N];

endmodule

// ---- cexu_regs.svh ----
// register addresses, field positions, reset values and fixed addresses of the exception entry unit
`ifndef CEXU_REGS_SVH
`define CEXU_REGS_SVH

// register byte addresses as seen in the control area
`define CEXU_EXC_EVENT_ADDR 32'hFF000024
`define CEXU_INT_EVENT_ADDR 32'hFF000028
`define CEXU_MASK_ADDR 32'hFF2F0004
// top three address bits that select the control area or its physical alias
`define CEXU_AREA_CTRL 3'h7
`define CEXU_AREA_PHYS 3'h0

// register widths
`define CEXU_EXC_CODE_W 12
`define CEXU_INT_CODE_W 14

// legacy feature mask fields
`define CEXU_MASK_RETURN_SLOT 0
`define CEXU_MASK_BRANCH_SLEEP 1
`define CEXU_MASK_ASSOC_WRITE 4
`define CEXU_MASK_WRITABLE 5'h13
`define CEXU_MASK_FIXED_ONES 5'h0C
`define CEXU_MASK_RESET 5'h1F

// reset values of the event code registers
`define CEXU_EXC_EVENT_RESET 12'h000
`define CEXU_INT_EVENT_RESET 14'h0000
`define CEXU_POWER_ON_CODE 12'h000

// status register fields
`define CEXU_SR_BLOCK 28
`define CEXU_SR_MODE 29
`define CEXU_SR_BANK 30
`define CEXU_SR_FP_DISABLE 15
`define CEXU_SR_INTERRUPT_MASK_LEVEL_LO 4
`define CEXU_SR_INTERRUPT_MASK_LEVEL_HI 7

// fixed reset target
`define CEXU_RESET_VECTOR 32'hA0000000

`endif

// ---- tb_cexu_entry_unit.sv ----
// self-checking bench for the exception entry unit
`timescale 1ns/1ps
`include "cexu_regs.svh"
module tb_cexu_entry_unit import cexu_pkg::*; ();
  logic clk, resetn, reg_wr, reg_rd, reg_ack, fd_set, irq_level_update_switch;
  logic return_from_exception_instr, icache_invalidate_instr, dec_valid, dec_in_return_slot, dec_is_nop;
  logic dec_in_branch_slot, dec_is_sleep, cache_assoc_req, slot_illegal_raise, addr_error_raise;
  logic cache_assoc_grant, entry_busy, entry_ack, sr_load, pc_load;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, saved_program_counter, saved_status, saved_general_reg;
  logic [31:0] sr_value, pc_value, cur_pc, cur_sr, cur_r15, vector_base, pre_pc, pre_sr;
  logic [7:0] req_pend;
  logic [23:0] req_level;
  logic [31:0] req_order;
  logic [95:0] req_code, req_offset;
  logic [15:0] req_kind;
  logic [3:0] irq_accept_level;
  logic [2:0] entry_idx;
  int failures, tests_run, cycles;

  cexu_entry_unit #(.N(8), .IW(3)) dut (.clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_ack, .req_pend, .req_level, .req_order, .req_code, .req_offset, .req_kind, .irq_accept_level,
    .irq_level_update_switch, .vector_base, .cur_pc, .cur_sr, .cur_r15, .return_from_exception_instr,
    .icache_invalidate_instr, .dec_valid, .dec_in_return_slot, .dec_is_nop, .dec_in_branch_slot, .dec_is_sleep,
    .cache_assoc_req, .slot_illegal_raise, .addr_error_raise, .cache_assoc_grant, .entry_busy, .entry_ack,
    .entry_idx, .saved_program_counter, .saved_status, .saved_general_reg, .sr_load, .sr_value, .pc_load,
    .pc_value);
  cexu_core_model u_core (.clk, .resetn, .fd_set, .sr_load, .sr_value, .pc_load, .pc_value, .cur_pc, .cur_sr,
    .cur_r15, .vector_base);

  // 10 MHz core clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one strobe cycle; released address and data are inverted so stale values never look valid
  task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk) #1;
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk) #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    chk("reg ack", reg_ack, 1'b1);
  endtask

  // f = {assoc, return slot, nop, branch slot, sleep}; answers come one cycle later
  task automatic probe(input logic [4:0] f, input logic ill, input logic ae);
    @(posedge clk) #1;
    {cache_assoc_req, dec_in_return_slot, dec_is_nop, dec_in_branch_slot, dec_is_sleep} = f;
    dec_valid = 1'b1;
    @(posedge clk) #1;
    dec_valid = 1'b0;
    cache_assoc_req = 1'b0;
    chk("slot illegal", slot_illegal_raise, ill);
    chk("addr error", addr_error_raise, ae);
    chk("assoc grant", cache_assoc_grant, f[4] & !ae);
  endtask

  // r = 1 return pulse, r = 0 with fd = 0 invalidate pulse, fd = fp disable set by the core
  task automatic strobe(input logic r, input logic fd);
    @(posedge clk) #1;
    return_from_exception_instr = r;
    icache_invalidate_instr = !r & !fd;
    fd_set = fd;
    @(posedge clk) #1;
    return_from_exception_instr = 1'b0;
    icache_invalidate_instr = 1'b0;
    fd_set = 1'b0;
  endtask

  task automatic src(input int i, input logic [1:0] k, input logic [6:0] key, input logic [11:0] c,
    input logic [11:0] o);
    req_kind[i*2 +: 2] = k;
    {req_level[i*3 +: 3], req_order[i*4 +: 4]} = key;
    req_code[i*12 +: 12] = c;
    req_offset[i*12 +: 12] = o;
  endtask

  // raise the pending set, hold it until the ack, then drop it
  task automatic run(input logic [7:0] p);
    int n;
    pre_pc = cur_pc;
    pre_sr = cur_sr;
    @(posedge clk) #1;
    req_pend = p;
    n = 0;
    while (entry_ack !== 1'b1 && n < 40) begin
      @(posedge clk) #1;
      n++;
    end
    chk("entry ack", entry_ack, 1'b1);
    req_pend = 8'h00;
    repeat (3) @(posedge clk) #1;
  endtask

  // run-away guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      stop_test();
    end
  end

  initial begin
    {resetn, reg_wr, reg_rd, fd_set, irq_level_update_switch, return_from_exception_instr} = 6'h00;
    {icache_invalidate_instr, dec_valid, dec_in_return_slot, dec_is_nop, dec_in_branch_slot} = 5'h00;
    {dec_is_sleep, cache_assoc_req, req_pend, irq_accept_level} = 14'h0000;
    {reg_addr, reg_wdata, req_level, req_order, req_code, req_offset, req_kind} = 328'h0;
    {failures, tests_run, cycles} = 96'h0;
    repeat (20) @(posedge clk);
    #1 resetn = 1'b1;
    run(8'h00);
    chk("power-on vector", pc_value, `CEXU_RESET_VECTOR);
    acc(0, `CEXU_EXC_EVENT_ADDR, 0);
    chk("exc code", reg_rdata, 32'h0);
    acc(0, `CEXU_MASK_ADDR, 0);
    chk("mask reset", reg_rdata, 32'h1F);
    acc(0, 32'hFF000030, 0);
    chk("unmapped", reg_rdata, 32'h0);
    acc(1, `CEXU_INT_EVENT_ADDR, 32'hFFFFFFFF);
    acc(0, 32'h1F000028, 0);
    chk("int code sw", reg_rdata, 32'h3FFF);
    // clear all writable mask bits; old mask stays active until read back and invalidate
    acc(1, `CEXU_MASK_ADDR, 0);
    acc(0, `CEXU_MASK_ADDR, 0);
    chk("mask cleared", reg_rdata, 32'h0C);
    probe(5'b01000, 0, 0);
    strobe(0, 0);
    probe(5'b01000, 1, 0);
    probe(5'b01100, 0, 0);
    probe(5'b00011, 1, 0);
    probe(5'b10000, 0, 1);
    acc(1, `CEXU_MASK_ADDR, 32'hFFFFFFFF);
    probe(5'b01000, 1, 0);
    acc(0, `CEXU_MASK_ADDR, 0);
    strobe(1, 0);
    probe(5'b01000, 0, 0);
    probe(5'b00011, 0, 0);
    probe(5'b10000, 0, 0);
    // three general events; level first, then order
    strobe(0, 1);
    src(2, 2'h1, 7'h25, 12'h100, 12'h100);
    src(5, 2'h1, 7'h22, 12'h040, 12'h400);
    src(6, 2'h1, 7'h30, 12'h1A0, 12'h100);
    run(8'h64);
    chk("winner", entry_idx, 3'h5);
    chk("vector", pc_value, vector_base + 32'h400);
    chk("saved pc", saved_program_counter, pre_pc);
    chk("saved sr", saved_status, pre_sr);
    chk("saved r15", saved_general_reg, cur_r15);
    chk("sr bits", sr_value[30:28], 3'h7);
    chk("fd kept", sr_value[15], 1'b1);
    acc(0, `CEXU_EXC_EVENT_ADDR, 0);
    chk("exc code", reg_rdata, 32'h040);
    strobe(1, 0);
    chk("return pc", pc_value, pre_pc);
    chk("return sr", sr_value, pre_sr);
    chk("r15 untouched", saved_general_reg, 32'h0C00FFF0);
    // accepted interrupt with the level update switch on
    irq_level_update_switch = 1'b1;
    irq_accept_level = 4'hA;
    src(3, 2'h2, 7'h40, 12'h3C0, 12'h600);
    run(8'h08);
    chk("interrupt_mask_level", sr_value[7:4], 4'hA);
    chk("irq vector", pc_value, vector_base + 32'h600);
    acc(0, `CEXU_INT_EVENT_ADDR, 0);
    chk("int code hw", reg_rdata, 32'h03C0);
    acc(0, `CEXU_EXC_EVENT_ADDR, 0);
    chk("exc untouched", reg_rdata, 32'h040);
    // manual reset entry clears fp disable and ignores the base
    strobe(0, 1);
    src(0, 2'h0, 7'h12, 12'h020, 12'h100);
    run(8'h01);
    chk("reset vector", pc_value, `CEXU_RESET_VECTOR);
    chk("fd cleared", sr_value[15], 1'b0);
    acc(0, `CEXU_EXC_EVENT_ADDR, 0);
    chk("reset code", reg_rdata, 32'h020);
    stop_test();
  end
endmodule
